/* File: inc/exc_lp_pkg.sv */
// Shared constants, register map and state record of the exception and low-power controller
package exc_lp_pkg;

  // Interrupt sources and vector codes
  localparam int IRQ_COUNT = 8;
  localparam int CODE_W = 4;
  localparam logic [3:0] CODE_SWI = 4'hF;   // Break and software interrupt share this vector
  localparam logic [3:0] CODE_NONE = 4'h0;

  // Bus geometry: printed offsets are register indices, byte address is four times that
  localparam int ADR_W = 18;
  localparam int IDX_W = 16;
  localparam logic [15:0] IDX_BREAK_STATUS = 16'hFE00;
  localparam logic [15:0] IDX_RESET_CAUSE = 16'hFE01;
  localparam logic [15:0] IDX_BREAK_CTRL = 16'hFE03;
  localparam logic [15:0] IDX_EXC_STATE = 16'hFE04;   // Read-only view of the sequencer

  // Field positions
  localparam int BIT_BREAK_LP = 1;   // break_exited_lowpower_flag in break_lowpower_status
  localparam int BIT_BREAK_CLEAR_ENABLE = 7;       // break_clear_enable in break_flag_control
  localparam int BIT_POR = 7;
  localparam int BIT_PIN = 6;
  localparam int BIT_COP = 5;
  localparam int BIT_ILOP = 4;
  localparam int BIT_ILAD = 3;
  localparam int BIT_LVI = 1;

  // Reset values
  localparam logic [7:0] RESET_CAUSE_RST = 8'h80;   // Power-up looks like a power-on reset
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // System counter and stop recovery, in crystal clock cycles
  localparam int CNT_W = 13;
  localparam int FULL_RECOVERY_CYC = 4096;
  localparam int SHORT_RECOVERY_CYC = 32;
  localparam int SERVICE_CLEAR_LSB = 4;   // Watchdog service clears counter bits 12..4

  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER} mode_t;

  // Whole register state of the controller
  typedef struct packed {
    mode_t mode;
    logic ack;
    logic [7:0] rdData;
    logic latchValid;
    logic [CODE_W-1:0] latchCode;
    logic pcMinusOne;
    logic entryDue;
    logic intEntry;
    logic restore;
    logic clearI;
    logic wokeByBreak;
    logic breakLp;
    logic break_clear_enable;
    logic [7:0] resetCause;
    logic [CNT_W-1:0] cnt;
    logic tick;
    logic shortRec;
    logic wdDisable;
    logic strapDone;
  } state_t;

endpackage

/* File: hdl/pin_synchronizer.sv */
// Three-stage synchroniser for an asynchronous pin with agreement filter
`timescale 1ns/1ns
module pin_synchronizer #(
  parameter logic IdleLevel = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic level
);

  // Stage chain plus the accepted level
  typedef struct packed {
    logic [2:0] stages;
    logic level;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  // Accept a change only once stages two and three agree; stage one feeds stage two only
  always_comb
  begin
    s_d = s_q;
    s_d.stages = {s_q.stages[1:0], pinIn};
    if (s_q.stages[1] == s_q.stages[2])
    begin
      s_d.level = s_q.stages[2];
    end
  end

  // Idle level under reset so a held-off pin reads inactive
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= {{3{IdleLevel}}, IdleLevel};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign level = s_q.level;

endmodule // pin_synchronizer

/* File: hdl/exception_and_lowpower_control.sv */
// Exception sequencing, break flag protection and wait/stop control
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
module exception_and_lowpower_control
  import exc_lp_pkg::*;
#(
  parameter int FullRecoveryCycles = exc_lp_pkg::FULL_RECOVERY_CYC,
  parameter int ShortRecoveryCycles = exc_lp_pkg::SHORT_RECOVERY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  // Classic Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [exc_lp_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // CPU core side
  input wire logic instrDone,
  input wire logic cpuIMask,
  input wire logic swiExec,
  input wire logic rtiExec,
  input wire logic waitExec,
  input wire logic stopExec,
  input wire logic vectorFetched,
  output logic intEntry,
  output logic [exc_lp_pkg::CODE_W-1:0] vectorCode,
  output logic stackPcMinusOne,
  output logic stackIndexHigh,
  output logic restoreRegs,
  output logic clearIMask,
  // Interrupt sources and break unit
  input wire logic [exc_lp_pkg::IRQ_COUNT-1:0] irqReq,
  input wire logic [exc_lp_pkg::IRQ_COUNT-1:0] irqEnable,
  input wire logic breakReq,
  output logic flagClearAllow,
  // Reset sources and straps
  input wire logic porReq,
  input wire logic resetPinN,
  input wire logic copReq,
  input wire logic ilopReq,
  input wire logic iladReq,
  input wire logic lviReq,
  input wire logic copService,
  input wire logic shortRecoveryOption,
  input wire logic watchdogDisableOption,
  output logic internalReset,
  output logic watchdogEnable,
  output logic copClockTick,
  output logic [exc_lp_pkg::CNT_W-1:0] sysCount,
  // Clock gating
  output logic cpuClkEn,
  output logic periphClkEn,
  output logic baseClockOutEn,
  output logic crystalClockEn
);

  import exc_lp_pkg::*;

  // Recovery counts must fit the 13-bit counter
  if (FullRecoveryCycles < 1 || FullRecoveryCycles > (1 << CNT_W) ||
      ShortRecoveryCycles < 1 || ShortRecoveryCycles > (1 << CNT_W))
  begin : gen_bad_recovery
    $error("Recovery counts must lie between 1 and the counter range");
  end

  localparam logic [CNT_W-1:0] FULL_LAST = CNT_W'(FullRecoveryCycles - 1);
  localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(ShortRecoveryCycles - 1);
  localparam logic [CNT_W-1:0] CNT_ALL_ONES = {CNT_W{1'b1}};

  state_t s_q;   // Registered state
  state_t s_d;   // Next state
  logic pinLevel;   // Filtered reset pin, high when released
  logic pinReset;   // External pin reset active
  logic internalSrc;   // Any reset from an internal source
  logic anyReset;   // Any reset source
  logic [IRQ_COUNT-1:0] pending;   // Requests whose enable is set
  logic [CODE_W-1:0] winner;   // Arbitration result
  logic busReq;   // New Wishbone request this cycle
  logic [IDX_W-1:0] regIdx;   // Register index from the byte address
  logic clearOk;   // Flags may be cleared now
  logic [CNT_W-1:0] recoverLast;   // Last count of the chosen recovery

  // Reset pin comes from outside the clock domain
  pin_synchronizer #(
    .IdleLevel(1'b1)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .pinIn(resetPinN),
    .level(pinLevel)
  );

  // Reset sources: all bypass arbitration with equal top priority
  assign pinReset = ~pinLevel;
  assign internalSrc = porReq | copReq | ilopReq | iladReq | lviReq;
  assign anyReset = internalSrc | pinReset;

  // Only enabled requests compete
  assign pending = irqReq & irqEnable;

  // Lowest index is highest priority; the result is a fixed code per source
  always_comb
  begin
    winner = CODE_NONE;
    for (int i = IRQ_COUNT - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        winner = CODE_W'(i);
      end
    end
  end

  assign busReq = cyc_i & stb_i & ~s_q.ack;
  assign regIdx = adr_i[ADR_W-1:2];
  // During break the reset cause byte is not cleared unless software allowed it
  assign clearOk = ~breakReq | s_q.break_clear_enable;
  assign recoverLast = s_q.shortRec ? SHORT_LAST : FULL_LAST;

  // Whole next-state computation
  always_comb
  begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.intEntry = 1'b0;
    s_d.restore = 1'b0;
    s_d.clearI = 1'b0;
    s_d.tick = 1'b0;

    // Straps are caught once after reset release and again on any reset
    if (!s_q.strapDone || anyReset)
    begin
      s_d.shortRec = shortRecoveryOption;
      s_d.wdDisable = watchdogDisableOption;
      s_d.strapDone = 1'b1;
    end

    // System counter: internal resets and stop clear it, the pin does not;
    // clearing on the stop instruction itself keeps it at zero all through stop
    if (internalSrc || s_q.mode == ST_STOP ||
        (s_q.mode == ST_RUN && stopExec && !waitExec && !pinReset))
    begin
      s_d.cnt = '0;
    end
    else if (copService && s_q.mode != ST_RECOVER)
    begin
      s_d.cnt = {(CNT_W - SERVICE_CLEAR_LSB)'(0), s_q.cnt[SERVICE_CLEAR_LSB-1:0]};
    end
    else
    begin
      s_d.cnt = s_q.cnt + 1'b1;
      s_d.tick = (s_q.cnt == CNT_ALL_ONES);
    end

    // Register access; one-cycle answer, unmapped indices read zero
    if (busReq)
    begin
      s_d.ack = 1'b1;
      s_d.rdData = BYTE_ZERO;
      unique case (regIdx)
        IDX_BREAK_STATUS:
        begin
          s_d.rdData[BIT_BREAK_LP] = s_q.breakLp;
          if (we_i && sel_i[0] && !dat_i[BIT_BREAK_LP])
          begin
            s_d.breakLp = 1'b0;
          end
        end
        IDX_RESET_CAUSE:
        begin
          s_d.rdData = s_q.resetCause;
          if (!we_i && clearOk)
          begin
            s_d.resetCause = BYTE_ZERO;
          end
        end
        IDX_BREAK_CTRL:
        begin
          s_d.rdData[BIT_BREAK_CLEAR_ENABLE] = s_q.break_clear_enable;
          if (we_i && sel_i[0])
          begin
            s_d.break_clear_enable = dat_i[BIT_BREAK_CLEAR_ENABLE];
          end
        end
        IDX_EXC_STATE:
        begin
          s_d.rdData = {s_q.mode, s_q.latchValid, s_q.pcMinusOne, s_q.latchCode};
        end
        default:
        begin
          s_d.rdData = BYTE_ZERO;
        end
      endcase
    end

    // Reset causes are set after any clear so a coinciding cause survives
    if (porReq)
    begin
      s_d.resetCause = RESET_CAUSE_RST;
    end
    else
    begin
      s_d.resetCause[BIT_PIN] = s_d.resetCause[BIT_PIN] | pinReset;
      s_d.resetCause[BIT_COP] = s_d.resetCause[BIT_COP] | copReq;
      s_d.resetCause[BIT_ILOP] = s_d.resetCause[BIT_ILOP] | ilopReq;
      s_d.resetCause[BIT_ILAD] = s_d.resetCause[BIT_ILAD] | iladReq;
      s_d.resetCause[BIT_LVI] = s_d.resetCause[BIT_LVI] | lviReq;
    end

    // Vector is held until the CPU has fetched it
    if (vectorFetched)
    begin
      s_d.latchValid = 1'b0;
    end

    // Return from interrupt pops the stacked registers
    if (rtiExec)
    begin
      s_d.restore = 1'b1;
    end

    // Delayed entry after a wake from wait or end of stop recovery
    if (s_q.entryDue)
    begin
      s_d.entryDue = 1'b0;
      s_d.intEntry = 1'b1;
    end

    // Exception and low-power sequencer
    if (anyReset)
    begin
      s_d.mode = ST_RUN;
      s_d.latchValid = 1'b0;
      s_d.entryDue = 1'b0;
      s_d.intEntry = 1'b0;
      s_d.breakLp = 1'b0;
      s_d.break_clear_enable = 1'b0;
    end
    else
    begin
      unique case (s_q.mode)
        ST_RUN:
        begin
          if (waitExec)
          begin
            s_d.mode = ST_WAIT;
            s_d.clearI = 1'b1;
          end
          else if (stopExec)
          begin
            s_d.mode = ST_STOP;
            s_d.clearI = 1'b1;
          end
          else if (instrDone && !s_q.latchValid && !s_q.entryDue)
          begin
            if (breakReq || swiExec)
            begin
              // Break and software interrupt take the shared vector regardless of mask
              s_d.latchValid = 1'b1;
              s_d.latchCode = CODE_SWI;
              s_d.pcMinusOne = 1'b0;
              s_d.intEntry = 1'b1;
            end
            else if (|pending && !cpuIMask)
            begin
              s_d.latchValid = 1'b1;
              s_d.latchCode = winner;
              s_d.pcMinusOne = 1'b1;
              s_d.intEntry = 1'b1;
            end
          end
        end
        ST_WAIT:
        begin
          if (breakReq)
          begin
            s_d.breakLp = 1'b1;
            s_d.mode = ST_RUN;
            s_d.latchValid = 1'b1;
            s_d.latchCode = CODE_SWI;
            s_d.pcMinusOne = 1'b0;
            s_d.entryDue = 1'b1;
          end
          else if (|pending)
          begin
            // Mask was cleared on entry, so the CPU copy is not consulted here
            s_d.mode = ST_RUN;
            s_d.latchValid = 1'b1;
            s_d.latchCode = winner;
            s_d.pcMinusOne = 1'b1;
            s_d.entryDue = 1'b1;
          end
        end
        ST_STOP:
        begin
          if (breakReq || |pending)
          begin
            s_d.mode = ST_RECOVER;
            s_d.wokeByBreak = breakReq;
            if (breakReq)
            begin
              s_d.breakLp = 1'b1;
            end
          end
        end
        ST_RECOVER:
        begin
          // Stacking waits for the chosen recovery count, full or short per strap
          if (s_q.cnt == recoverLast)
          begin
            s_d.mode = ST_RUN;
            s_d.latchValid = 1'b1;
            s_d.entryDue = 1'b1;
            if (s_q.wokeByBreak || !(|pending))
            begin
              // A request that vanished during recovery falls back to the break vector
              s_d.latchCode = CODE_SWI;
              s_d.pcMinusOne = 1'b0;
            end
            else
            begin
              s_d.latchCode = winner;
              s_d.pcMinusOne = 1'b1;
            end
          end
        end
        default:
        begin
          s_d.mode = ST_RUN;
        end
      endcase
    end
  end

  // Single state register; power-up behaves as a power-on reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '{mode: ST_RUN, ack: 1'b0, rdData: BYTE_ZERO, latchValid: 1'b0,
               latchCode: CODE_NONE, pcMinusOne: 1'b0, entryDue: 1'b0,
               intEntry: 1'b0, restore: 1'b0, clearI: 1'b0, wokeByBreak: 1'b0,
               breakLp: 1'b0, break_clear_enable: 1'b0, resetCause: RESET_CAUSE_RST,
               cnt: '0, tick: 1'b0, shortRec: 1'b0, wdDisable: 1'b0,
               strapDone: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Bus outputs; narrow data in the low byte
  assign dat_o = {24'h000000, s_q.rdData};
  assign ack_o = s_q.ack;

  // CPU-facing outputs
  assign intEntry = s_q.intEntry;
  assign vectorCode = s_q.latchCode;
  assign stackPcMinusOne = s_q.pcMinusOne;
  // Handlers that touch the index high register must save it themselves
  assign stackIndexHigh = 1'b0;
  assign restoreRegs = s_q.restore;
  assign clearIMask = s_q.clearI;

  // Other modules gate their clear paths with this; a first step taken
  // before break does not open the second step while break lasts
  assign flagClearAllow = clearOk;

  // Reset, watchdog and counter outputs
  assign internalReset = anyReset;
  assign watchdogEnable = ~s_q.wdDisable;
  assign copClockTick = s_q.tick;
  assign sysCount = s_q.cnt;

  // Clock gating per mode
  assign cpuClkEn = (s_q.mode == ST_RUN);
  assign periphClkEn = (s_q.mode == ST_RUN) || (s_q.mode == ST_WAIT);
  assign baseClockOutEn = (s_q.mode == ST_RUN) || (s_q.mode == ST_WAIT);
  assign crystalClockEn = (s_q.mode != ST_STOP);

endmodule // exception_and_lowpower_control

/* File: tb/exc_lp_properties.sv */
// Concurrent checks on the ports of the exception and low-power controller
`timescale 1ns/1ns
module exc_lp_properties #(
  parameter int FullRecoveryCycles = 4096,
  parameter int ShortRecoveryCycles = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic waitExec,
  input wire logic stopExec,
  input wire logic rtiExec,
  input wire logic intEntry,
  input wire logic [exc_lp_pkg::CODE_W-1:0] vectorCode,
  input wire logic stackPcMinusOne,
  input wire logic stackIndexHigh,
  input wire logic restoreRegs,
  input wire logic clearIMask,
  input wire logic breakReq,
  input wire logic flagClearAllow,
  input wire logic copService,
  input wire logic watchdogDisableOption,
  input wire logic internalReset,
  input wire logic watchdogEnable,
  input wire logic [exc_lp_pkg::CNT_W-1:0] sysCount,
  input wire logic cpuClkEn,
  input wire logic periphClkEn,
  input wire logic baseClockOutEn,
  input wire logic crystalClockEn
);
  import exc_lp_pkg::*;
  // Everything here runs on the one system clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Bus slave answers one cycle after a fresh request, for exactly one cycle
  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_index_high_never: assert property (stackIndexHigh == 1'b0) else $error("H stacked");
  a_entry_pc_kind: assert property (intEntry |->
    (stackPcMinusOne == (vectorCode != CODE_SWI))) else $error("stacked PC kind wrong");
  a_entry_one_pulse: assert property (intEntry |=> !intEntry) else $error("entry held");
  a_clear_gate_idle: assert property (!breakReq |-> flagClearAllow)
    else $error("clear gated");
  // Wait keeps peripherals clocked; stop kills every clock
  a_wait_clocks_gated: assert property (
    waitExec && cpuClkEn && !stopExec && !internalReset |=>
    clearIMask && !cpuClkEn && periphClkEn) else $error("wait entry wrong");
  a_stop_clocks_off: assert property (
    stopExec && cpuClkEn && !waitExec && !internalReset |=>
    clearIMask && !periphClkEn && !baseClockOutEn && !crystalClockEn)
    else $error("stop entry wrong");
  a_stop_count_held: assert property (!crystalClockEn |-> sysCount == 13'h0000)
    else $error("count ran");
  // Counter runs freely whenever the crystal clock is on and nothing clears it;
  // the edge that still sees reset is left out, the counter is held there
  a_count_free_run: assert property (
    !rst && crystalClockEn && !internalReset && !copService && !stopExec |=>
    sysCount == 13'($past(sysCount) + 13'h0001)) else $error("count not free");
  a_rti_restores: assert property (rtiExec && !internalReset |=> restoreRegs)
    else $error("no restore");
  a_watchdog_strap: assert property (!$past(rst) |->
    watchdogEnable == !watchdogDisableOption) else $error("watchdog strap");

  c_swi_entry: cover property (intEntry && vectorCode == CODE_SWI);
  c_stop_exit: cover property (!crystalClockEn ##1 crystalClockEn);
  c_restore: cover property (restoreRegs);
  c_wait_state: cover property (!cpuClkEn && periphClkEn);
endmodule // exc_lp_properties

bind exception_and_lowpower_control exc_lp_properties #(
  .FullRecoveryCycles(FullRecoveryCycles),
  .ShortRecoveryCycles(ShortRecoveryCycles)
) u_props (.*);

/* File: tb/cpu_core_model.sv */
// Behavioural CPU core: paces instructions and follows the controller's mask commands
`timescale 1ns/1ns
module cpu_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic cpuClkEn,
  input wire logic intEntry,
  input wire logic clearIMask,
  input wire logic restoreRegs,
  input wire logic internalReset,
  input wire logic [2:0] cmd,
  output logic instrDone,
  output logic cpuIMask,
  output logic swiExec,
  output logic rtiExec,
  output logic waitExec,
  output logic stopExec,
  output logic vectorFetched,
  output logic cmdTaken
);
  logic [1:0] phase_q; // Four cycles per instruction, frozen while unclocked
  logic [1:0] fetch_q; // Vector fetch lags entry by three cycles
  logic go; // Instruction boundary this cycle
  assign go = cpuClkEn && (phase_q == 2'h3);
  // Boundary pulses carry the commanded special instruction, if any
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {phase_q, fetch_q, instrDone, cpuIMask, swiExec, rtiExec} <= '0;
      {waitExec, stopExec, vectorFetched, cmdTaken} <= '0;
    end
    else
    begin
      phase_q <= cpuClkEn ? phase_q + 2'h1 : phase_q;
      instrDone <= go;
      swiExec <= go && (cmd == 3'h1);
      rtiExec <= go && (cmd == 3'h2);
      waitExec <= go && (cmd == 3'h3);
      stopExec <= go && (cmd == 3'h4);
      cmdTaken <= go && (cmd != 3'h0);
      fetch_q <= {fetch_q[0], intEntry};
      vectorFetched <= fetch_q[1];
      // Mask set on entry, dropped by low-power entry, return or reset
      if (internalReset || clearIMask || restoreRegs)
        cpuIMask <= 1'b0;
      else if (intEntry)
        cpuIMask <= 1'b1;
    end
  end
endmodule // cpu_core_model

/* File: tb/exception_and_lowpower_control_tb_top.sv */
// Self-checking bench for the exception and low-power controller
`timescale 1ns/1ns
module exception_and_lowpower_control_tb_top;
  import exc_lp_pkg::*;
  localparam int FullT = 64; // Shortened recovery counts keep the run brief
  localparam int ShortT = 8;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [17:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] datI = '0, datO;
  logic ack, instrDone, cpuIMask, swiExec, rtiExec, waitExec, stopExec, vectorFetched, cmdTaken;
  logic intEntry, stackPcMinusOne, stackIndexHigh, restoreRegs, clearIMask, flagClearAllow;
  logic [3:0] vectorCode;
  logic [7:0] irqReq = '0, irqEnable = '0, rd;
  logic [4:0] srcs = '0; // cop, ilop, ilad, lvi, por
  logic breakReq = 1'b0, resetPinN = 1'b1, shortOpt = 1'b0, wdOpt = 1'b0;
  logic internalReset, watchdogEnable, copClockTick, cpuClkEn, periphClkEn, baseEn, xtalEn;
  logic [12:0] sysCount, c0;
  logic [2:0] cmd = 3'h0;
  int mismatches = 0, cmp_count = 0, cycles = 0, n, i, j;

  always #20 clk = ~clk;

  exception_and_lowpower_control #(.FullRecoveryCycles(FullT), .ShortRecoveryCycles(ShortT))
    u_dut (
    .clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(datI), .dat_o(datO), .ack_o(ack), .instrDone(instrDone), .cpuIMask(cpuIMask),
    .swiExec(swiExec), .rtiExec(rtiExec), .waitExec(waitExec), .stopExec(stopExec),
    .vectorFetched(vectorFetched), .intEntry(intEntry), .vectorCode(vectorCode),
    .stackPcMinusOne(stackPcMinusOne), .stackIndexHigh(stackIndexHigh),
    .restoreRegs(restoreRegs), .clearIMask(clearIMask), .irqReq(irqReq), .irqEnable(irqEnable),
    .breakReq(breakReq), .flagClearAllow(flagClearAllow), .porReq(srcs[4]),
    .resetPinN(resetPinN), .copReq(srcs[0]), .ilopReq(srcs[1]), .iladReq(srcs[2]),
    .lviReq(srcs[3]), .copService(1'b0), .shortRecoveryOption(shortOpt),
    .watchdogDisableOption(wdOpt), .internalReset(internalReset),
    .watchdogEnable(watchdogEnable), .copClockTick(copClockTick), .sysCount(sysCount),
    .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .baseClockOutEn(baseEn),
    .crystalClockEn(xtalEn));

  cpu_core_model u_cpu (.clk(clk), .rst(rst), .cpuClkEn(cpuClkEn), .intEntry(intEntry),
    .clearIMask(clearIMask), .restoreRegs(restoreRegs), .internalReset(internalReset),
    .cmd(cmd), .instrDone(instrDone), .cpuIMask(cpuIMask), .swiExec(swiExec),
    .rtiExec(rtiExec), .waitExec(waitExec), .stopExec(stopExec),
    .vectorFetched(vectorFetched), .cmdTaken(cmdTaken));

  // Expected reset cause byte for source s; power-on wipes all other flags
  function automatic logic [7:0] cause_exp(input int s);
    logic [7:0] bits [5] = '{8'h20, 8'h10, 8'h08, 8'h02, 8'h80};
    return bits[s];
  endfunction

  task automatic finish_test();
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_num(input string nm, input logic [12:0] e, input logic [12:0] g);
    chk_reg(nm, e[7:0], g[7:0]);
    chk_reg({nm, " high"}, {3'h0, e[12:8]}, {3'h0, g[12:8]});
  endtask

  // Classic single Wishbone cycle; the answer is taken at the edge that sees ack
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge clk);
    {cyc, stb, we, sel} <= {1'b1, 1'b1, w, 4'hF};
    adr <= {idx, 2'h0};
    datI <= {24'h000000, wd};
    // Ack ends this wait; it has no bound of its own, only the bench timeout stops it if ack never comes
    do
      @(posedge clk);
    while (ack !== 1'b1);
    rd = datO[7:0];
    {cyc, stb, we} <= 3'h0;
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk_reg($sformatf("reg %h", idx), e, rd);
  endtask

  // Hand a special instruction to the core model and wait until it is issued
  task automatic cpu_op(input logic [2:0] v);
    @(posedge clk);
    cmd <= v;
    n = 0;
    do
      @(negedge clk);
    while (cmdTaken !== 1'b1 && ++n < 50);
    @(posedge clk);
    cmd <= 3'h0;
  endtask

  // Count falling edges until an interrupt entry shows, bounded
  task automatic wait_entry(input int lim);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (intEntry !== 1'b1 && n < lim);
  endtask

  task automatic do_reset(input logic so, input logic wo);
    rst <= 1'b1;
    shortOpt <= so;
    wdOpt <= wo;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Stop, wake by an interrupt and time the recovery
  task automatic do_stop(input int t);
    cpu_op(3'h4);
    @(negedge clk);
    chk_reg("stop clocks", 8'h00, {4'h0, cpuClkEn, periphClkEn, baseEn, xtalEn});
    @(posedge clk);
    irqReq <= 8'h02;
    irqEnable <= 8'h02;
    wait_entry(t + 40);
    chk_reg("stop recovery", 8'h01, {7'h00, n >= t + 2 && n <= t + 4});
    chk_reg("stop code", 8'h01, {4'h0, vectorCode});
    @(posedge clk);
    irqReq <= 8'h00;
    cpu_op(3'h2);
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      finish_test();
    end
  end

  initial
  begin
    void'($urandom(92720));
    do_reset(1'b0, 1'b0);
    chk_reg("watchdog on", 8'h01, {7'h00, watchdogEnable});
    rd_chk(IDX_RESET_CAUSE, RESET_CAUSE_RST);
    rd_chk(IDX_RESET_CAUSE, BYTE_ZERO);
    rd_chk(IDX_BREAK_STATUS, BYTE_ZERO);
    rd_chk(IDX_BREAK_CTRL, BYTE_ZERO);
    rd_chk(16'hFE02, BYTE_ZERO);
    wb(1'b1, IDX_BREAK_CTRL, 8'h80);
    rd_chk(IDX_BREAK_CTRL, 8'h80);
    wb(1'b1, IDX_BREAK_CTRL, 8'h00);
    // Every internal reset source leaves only its own flag
    for (int s = 0; s < 5; s++)
    begin
      @(posedge clk);
      srcs <= 5'(1 << s);
      @(posedge clk);
      srcs <= 5'h00;
      repeat (4) @(posedge clk);
      rd_chk(IDX_RESET_CAUSE, cause_exp(s));
    end
    // Pin reset must not disturb the free-running counter
    @(negedge clk);
    c0 = sysCount;
    @(posedge clk);
    resetPinN <= 1'b0;
    repeat (8) @(posedge clk);
    resetPinN <= 1'b1;
    repeat (11) @(negedge clk);
    chk_num("counter across pin reset", 13'(c0 + 13'h0013), sysCount);
    repeat (6) @(posedge clk);
    rd_chk(IDX_RESET_CAUSE, 8'h40);
    // Random source, first disabled then enabled
    i = 1 + $urandom % 7;
    j = 1 + i % 7;
    @(posedge clk);
    irqReq <= 8'(1 << i);
    irqEnable <= 8'($urandom) & ~8'(1 << i);
    wait_entry(20);
    chk_reg("disabled source taken", 8'h00, {7'h00, intEntry});
    @(posedge clk);
    irqEnable <= 8'hFF;
    wait_entry(20);
    chk_reg("hw code", 8'(i + 16), {3'h0, stackPcMinusOne, vectorCode});
    @(posedge clk);
    irqReq <= 8'(1 << j);
    wait_entry(24);
    chk_reg("masked displaced", 8'h00, {7'h00, intEntry});
    cpu_op(3'h1);
    wait_entry(10);
    chk_reg("swi code", {4'h0, CODE_SWI}, {3'h0, stackPcMinusOne, vectorCode});
    cpu_op(3'h2);
    wait_entry(20);
    chk_reg("return pending", 8'(j + 16), {3'h0, stackPcMinusOne, vectorCode});
    @(posedge clk);
    irqReq <= 8'h00;
    cpu_op(3'h2);
    // Wait mode woken by an enabled source
    cpu_op(3'h3);
    @(negedge clk);
    chk_reg("wait clocks", 8'h01, {6'h00, cpuClkEn, periphClkEn});
    @(posedge clk);
    irqReq <= 8'h08;
    wait_entry(10);
    chk_reg("wait wake delay", 8'h01, {7'h00, n >= 3 && n <= 4});
    @(posedge clk);
    irqReq <= 8'h00;
    cpu_op(3'h2);
    // Break ends wait, flags it, and gates flag clearing
    cpu_op(3'h3);
    @(posedge clk);
    breakReq <= 1'b1;
    wait_entry(10);
    chk_reg("break code", {4'h0, CODE_SWI}, {4'h0, vectorCode});
    chk_reg("clear gated", 8'h00, {7'h00, flagClearAllow});
    wb(1'b1, IDX_BREAK_CTRL, 8'h80);
    @(negedge clk);
    chk_reg("clear enabled", 8'h01, {7'h00, flagClearAllow});
    wb(1'b1, IDX_BREAK_CTRL, 8'h00);
    rd_chk(IDX_BREAK_STATUS, 8'h02);
    breakReq <= 1'b0;
    wb(1'b1, IDX_BREAK_STATUS, 8'h00);
    rd_chk(IDX_BREAK_STATUS, BYTE_ZERO);
    cpu_op(3'h2);
    do_stop(FullT);
    do_reset(1'b1, 1'b1);
    chk_reg("watchdog off", 8'h00, {7'h00, watchdogEnable});
    do_stop(ShortT);
    finish_test();
  end
endmodule // exception_and_lowpower_control_tb_top
